// ==== design/acc_ctrl.sv ====
// adc channel setup registers, source decode, conversion clock and sequencing
`timescale 1ns/1ns
`include "acc_consts.svh"
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] conv_result,
  output logic conv_clk,
  output logic conv_busy,
  output logic cpu_halt,
  output acc_analog_t analog_cfg
);
  logic [15:0] c1a_r, c1b_r, c2a_r, c2b_r, ta_r, tb_r, ctrl_r;
  logic [15:0] data1_r, data2_r, datat_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, conv_clk_r, busy_r;
  acc_analog_t cfg_r, cfg_nxt;
  logic [15:0] sel_a, sel_b;
  logic [15:0] conv_cnt_r, conv_len;
  logic [11:0] div_cnt_r;
  logic [11:0] half_end;
  logic [8:0] pre_cnt_r;
  logic tick;
  logic [7:0] idx;
  logic access, wr_ok, addr_ok, done, start_wr;
  logic gain_bad_r;
  acc_ch_t ch_r, ch_nxt;
  typedef enum {ACC_IDLE, ACC_RUN} acc_state_t;
  acc_state_t state_r;

  assign idx = paddr[9:2];
  assign access = psel && penable && !pready_r;
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0) begin
      addr_ok = 1'b0;
    end else if (idx <= `ACC_IDX_STATUS) begin
      addr_ok = 1'b1;
    end
  end
  // writes during a conversion are refused so settings cannot change mid-run
  assign wr_ok = access && pwrite && addr_ok && !busy_r;
  assign start_wr = wr_ok && idx == `ACC_IDX_CONTROL
    && (pwdata[2:0] != 3'h0);

  // one-wait apb slave; data and ready both from flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= access;
      pslverr_r <= access && (!addr_ok || (pwrite && busy_r));
      prdata_r <= 32'h0;
      if (access && !pwrite && addr_ok) begin
        if (idx == `ACC_IDX_CONTROL) begin
          prdata_r <= {16'h0, ctrl_r};
        end else if (idx == `ACC_IDX_DATA1) begin
          prdata_r <= {16'h0, data1_r};
        end else if (idx == `ACC_IDX_C1A) begin
          prdata_r <= {16'h0, c1a_r};
        end else if (idx == `ACC_IDX_C1B) begin
          prdata_r <= {16'h0, c1b_r};
        end else if (idx == `ACC_IDX_DATA2) begin
          prdata_r <= {16'h0, data2_r};
        end else if (idx == `ACC_IDX_C2A) begin
          prdata_r <= {16'h0, c2a_r};
        end else if (idx == `ACC_IDX_C2B) begin
          prdata_r <= {16'h0, c2b_r};
        end else if (idx == `ACC_IDX_DATAT) begin
          prdata_r <= {16'h0, datat_r};
        end else if (idx == `ACC_IDX_TA) begin
          prdata_r <= {16'h0, ta_r};
        end else if (idx == `ACC_IDX_TB) begin
          prdata_r <= {16'h0, tb_r};
        end else begin
          prdata_r <= {30'h0, gain_bad_r, busy_r};
        end
      end
    end
  end

  // setup registers keep only defined bits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      c1a_r <= `ACC_RST_A;
      c1b_r <= `ACC_RST_B;
      c2a_r <= `ACC_RST_A;
      c2b_r <= `ACC_RST_B;
      ta_r <= `ACC_RST_A;
      tb_r <= `ACC_RST_B;
    end else if (wr_ok) begin
      if (idx == `ACC_IDX_C1A) begin
        c1a_r <= pwdata[15:0] & `ACC_MASK_A;
      end else if (idx == `ACC_IDX_C1B) begin
        c1b_r <= pwdata[15:0] & `ACC_MASK_B;
      end else if (idx == `ACC_IDX_C2A) begin
        c2a_r <= pwdata[15:0] & `ACC_MASK_A;
      end else if (idx == `ACC_IDX_C2B) begin
        c2b_r <= pwdata[15:0] & `ACC_MASK_B;
      end else if (idx == `ACC_IDX_TA) begin
        ta_r <= pwdata[15:0] & `ACC_MASK_A;
      end else if (idx == `ACC_IDX_TB) begin
        tb_r <= pwdata[15:0] & `ACC_MASK_TB;
      end
    end
  end

  // channel 1 has priority over 2, and 2 over temperature
  always_comb begin
    ch_nxt = ACC_CH_NONE;
    if (pwdata[`ACC_START1_BIT]) begin
      ch_nxt = ACC_CH_ONE;
    end else if (pwdata[`ACC_START2_BIT]) begin
      ch_nxt = ACC_CH_TWO;
    end else if (pwdata[`ACCT_START_BIT] && pwdata[`ACC_SE_MSB:`ACC_SE_LSB] == 4'h0) begin
      ch_nxt = ACC_CH_TEMP;
    end
  end

  always_comb begin
    sel_a = ta_r;
    sel_b = tb_r;
    if (ch_r == ACC_CH_ONE) begin
      sel_a = c1a_r;
      sel_b = c1b_r;
    end else if (ch_r == ACC_CH_TWO) begin
      sel_a = c2a_r;
      sel_b = c2b_r;
    end
  end

  // analog setup for the running conversion
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.channel = ch_r;
    cfg_nxt.minus_is_ground = ctrl_r[`ACC_SE_MSB:`ACC_SE_LSB] != 4'h0;
    cfg_nxt.amp_gain_code = sel_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB];
    cfg_nxt.resolution_code = sel_a[`ACC_RES_MSB:`ACC_RES_LSB];
    cfg_nxt.coarse_offset_sign = sel_a[`ACC_SIGN_BIT];
    cfg_nxt.coarse_offset_magnitude = sel_a[`ACC_MAG_MSB:0];
    cfg_nxt.bias_level_code = sel_b[`ACC_BIAS_MSB:`ACC_BIAS_LSB];
    if (ch_r == ACC_CH_TEMP) begin
      cfg_nxt.reference_select = ACC_REF_SUPPLY;
    end else if (sel_b[`ACC_REF_MSB]) begin
      cfg_nxt.reference_select = ACC_REF_BG4X;
    end else if (sel_b[0]) begin
      cfg_nxt.reference_select = ACC_REF_EXT2X;
    end else begin
      cfg_nxt.reference_select = ACC_REF_SUPPLY;
    end
    case (ctrl_r[`ACC_SE_MSB:`ACC_SE_LSB])
      ACC_SE_DIFF: cfg_nxt.plus_node = (ch_r == ACC_CH_TEMP) ? ACC_NODE_NONE : ACC_NODE_POS_PIN;
      ACC_SE_POS: cfg_nxt.plus_node = ACC_NODE_POS_PIN;
      ACC_SE_NEG: cfg_nxt.plus_node = ACC_NODE_NEG_PIN;
      ACC_SE_SMALL: cfg_nxt.plus_node = ACC_NODE_SMALL_AMP;
      ACC_SE_LARGE: cfg_nxt.plus_node = ACC_NODE_LARGE_AMP;
      ACC_SE_BANDGAP: cfg_nxt.plus_node = ACC_NODE_BANDGAP;
      ACC_SE_SUPPLY: cfg_nxt.plus_node = ACC_NODE_SUPPLY;
      ACC_SE_GROUND: cfg_nxt.plus_node = ACC_NODE_GROUND;
      ACC_SE_DAC_SMALL: cfg_nxt.plus_node = ACC_NODE_DAC_SMALL;
      ACC_SE_DAC_LARGE: cfg_nxt.plus_node = ACC_NODE_DAC_LARGE;
      default: cfg_nxt.plus_node = ACC_NODE_NONE;
    endcase
    // the reduced gain is forced for these source codes, whatever the gain field holds
    if (ctrl_r[`ACC_SE_MSB:`ACC_SE_LSB] >= 4'h4 && ctrl_r[`ACC_SE_MSB:`ACC_SE_LSB] <= 4'h7) begin
      cfg_nxt.gain_forced = 1'b1;
      cfg_nxt.amp_gain_code = `ACC_GAIN_FORCED;
    end
    case (sel_a[`ACC_RES_MSB:`ACC_RES_LSB])
      3'h0: cfg_nxt.res_bits = 4'h9;
      3'h1: cfg_nxt.res_bits = 4'hA;
      3'h2: cfg_nxt.res_bits = 4'hC;
      3'h3: cfg_nxt.res_bits = 4'hD;
      3'h4: cfg_nxt.res_bits = 4'hE;
      3'h5: cfg_nxt.res_bits = 4'hF;
      default: cfg_nxt.res_bits = 4'h0;
    endcase
    case (sel_a[`ACC_RES_MSB:`ACC_RES_LSB])
      3'h0: conv_len = `ACC_LEN_RES0;
      3'h1: conv_len = `ACC_LEN_RES1;
      3'h2: conv_len = `ACC_LEN_RES2;
      3'h3: conv_len = `ACC_LEN_RES3;
      3'h4: conv_len = `ACC_LEN_RES4;
      3'h5: conv_len = `ACC_LEN_RES5;
      default: conv_len = `ACC_LEN_RES6;
    endcase
  end

  // 4 MHz reference tick from the system clock, then divide by 4 << code
  assign tick = pre_cnt_r == 9'(`ACC_PRE_DIV - 1);
  assign half_end = 12'((`ACC_BASE_DIV / 2) << sel_a[`ACC_CLK_MSB:`ACC_CLK_LSB]) - 12'h1;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_r <= 9'h0;
      div_cnt_r <= 12'h0;
      conv_clk_r <= 1'b0;
    end else begin
      pre_cnt_r <= tick ? 9'h0 : pre_cnt_r + 9'h1;
      if (state_r != ACC_RUN) begin
        div_cnt_r <= 12'h0;
        conv_clk_r <= 1'b0;
      end else if (tick) begin
        // half period in reference ticks is 2 << code
        if (div_cnt_r == half_end) begin
          div_cnt_r <= 12'h0;
          conv_clk_r <= !conv_clk_r;
        end else begin
          div_cnt_r <= div_cnt_r + 12'h1;
        end
      end
    end
  end

  assign done = state_r == ACC_RUN && conv_cnt_r == conv_len;
  // sequencing: start bits stay set while running and clear on completion
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ACC_IDLE;
      ctrl_r <= `ACC_RST_CTRL;
      ch_r <= ACC_CH_NONE;
      busy_r <= 1'b0;
      conv_cnt_r <= 16'h0;
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      case (state_r)
        ACC_IDLE: begin
          conv_cnt_r <= 16'h0;
          if (wr_ok && idx == `ACC_IDX_CONTROL) begin
            ctrl_r <= pwdata[15:0] & `ACC_MASK_CTRL;
          end
          if (start_wr && ch_nxt != ACC_CH_NONE) begin
            ch_r <= ch_nxt;
            busy_r <= 1'b1;
            state_r <= ACC_RUN;
          end
        end
        ACC_RUN: begin
          if (tick && div_cnt_r == 12'h0 && conv_clk_r) begin
            conv_cnt_r <= conv_cnt_r + 16'h1;
          end
          if (done) begin
            ctrl_r[2:0] <= 3'h0;
            busy_r <= 1'b0;
            ch_r <= ACC_CH_NONE;
            state_r <= ACC_IDLE;
          end
        end
        default: state_r <= ACC_IDLE;
      endcase
    end
  end

  // result store and gain code check
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      data1_r <= 16'h0;
      data2_r <= 16'h0;
      datat_r <= 16'h0;
      gain_bad_r <= 1'b0;
    end else begin
      if (done && ch_r == ACC_CH_ONE) begin
        data1_r <= conv_result;
      end else if (done && ch_r == ACC_CH_TWO) begin
        data2_r <= conv_result;
      end else if (done && ch_r == ACC_CH_TEMP) begin
        datat_r <= conv_result;
      end
      // above code 8 only the even codes of the gain table exist, except 0x12, 0x16 and 0x1A
      gain_bad_r <= sel_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB] > 5'h08
        && (sel_a[`ACC_GAIN_LSB] || sel_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB] == 5'h12
        || sel_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB] == 5'h16
        || sel_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB] == 5'h1A);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_clk = conv_clk_r;
  assign conv_busy = busy_r;
  assign cpu_halt = busy_r;
  assign analog_cfg = cfg_r;
endmodule

// ==== design/acc_consts.svh ====
// register offsets, field positions, reset values and timing constants of the adc setup block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_IDX_CONTROL 8'h00
`define ACC_IDX_DATA1 8'h01
`define ACC_IDX_C1A 8'h02
`define ACC_IDX_C1B 8'h03
`define ACC_IDX_DATA2 8'h04
`define ACC_IDX_C2A 8'h05
`define ACC_IDX_C2B 8'h06
`define ACC_IDX_DATAT 8'h07
`define ACC_IDX_TA 8'h08
`define ACC_IDX_TB 8'h09
`define ACC_IDX_STATUS 8'h0A
`define ACC_MASK_A 16'hFF7F
`define ACC_MASK_B 16'h0073
`define ACC_MASK_TB 16'h0070
`define ACC_MASK_CTRL 16'h0F07
`define ACC_RST_A 16'h0000
`define ACC_RST_B 16'h0070
`define ACC_RST_CTRL 16'h0000
`define ACC_GAIN_MSB 15
`define ACC_GAIN_LSB 11
`define ACC_CLK_MSB 10
`define ACC_CLK_LSB 8
`define ACC_RES_MSB 6
`define ACC_RES_LSB 4
`define ACC_SIGN_BIT 3
`define ACC_MAG_MSB 2
`define ACC_BIAS_MSB 6
`define ACC_BIAS_LSB 4
`define ACC_REF_MSB 1
`define ACC_SE_MSB 11
`define ACC_SE_LSB 8
`define ACC_START1_BIT 2
`define ACC_START2_BIT 1
`define ACCT_START_BIT 0
`define ACC_BASE_DIV 4
`define ACC_SYS_CLK_HZ 100000000
`define ACC_CONV_REF_HZ 4000000
`define ACC_PRE_DIV (`ACC_SYS_CLK_HZ / `ACC_CONV_REF_HZ)
`define ACC_GAIN_FORCED 5'h1F
`define ACC_LEN_RES0 16'h0100
`define ACC_LEN_RES1 16'h0140
`define ACC_LEN_RES2 16'h0200
`define ACC_LEN_RES3 16'h0280
`define ACC_LEN_RES4 16'h0320
`define ACC_LEN_RES5 16'h0500
`define ACC_LEN_RES6 16'h0800
`endif

// ==== design/acc_pkg.sv ====
// types shared by the adc setup block
package acc_pkg;
  typedef enum logic [3:0] {
    ACC_SE_DIFF = 4'h0, ACC_SE_BANDGAP = 4'h1, ACC_SE_SMALL = 4'h2, ACC_SE_LARGE = 4'h3,
    ACC_SE_SUPPLY = 4'h4, ACC_SE_GROUND = 4'h5, ACC_SE_DAC_SMALL = 4'h6,
    ACC_SE_DAC_LARGE = 4'h7, ACC_SE_POS = 4'h8, ACC_SE_NEG = 4'h9
  } acc_se_t;
  typedef enum logic [3:0] {
    ACC_NODE_NONE = 4'h0, ACC_NODE_POS_PIN = 4'h1, ACC_NODE_NEG_PIN = 4'h2,
    ACC_NODE_SMALL_AMP = 4'h3, ACC_NODE_LARGE_AMP = 4'h4, ACC_NODE_BANDGAP = 4'h5,
    ACC_NODE_SUPPLY = 4'h6, ACC_NODE_GROUND = 4'h7, ACC_NODE_DAC_SMALL = 4'h8,
    ACC_NODE_DAC_LARGE = 4'h9
  } acc_node_t;
  typedef enum logic [1:0] {
    ACC_REF_SUPPLY = 2'h0, ACC_REF_EXT2X = 2'h1, ACC_REF_BG4X = 2'h2
  } acc_ref_t;
  typedef enum logic [1:0] {
    ACC_CH_NONE = 2'h0, ACC_CH_ONE = 2'h1, ACC_CH_TWO = 2'h2, ACC_CH_TEMP = 2'h3
  } acc_ch_t;
  // settings presented to the analog converter for the running conversion
  typedef struct packed {
    acc_ch_t channel;
    acc_node_t plus_node;
    logic minus_is_ground;
    logic [4:0] amp_gain_code;
    logic gain_forced;
    logic [2:0] resolution_code;
    logic [3:0] res_bits;
    logic coarse_offset_sign;
    logic [2:0] coarse_offset_magnitude;
    logic [2:0] bias_level_code;
    acc_ref_t reference_select;
  } acc_analog_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } acc_apb_req_t;
endpackage

// ==== tb/acc_ctrl_properties.sv ====
// port-level assertions for the adc setup block
`timescale 1ns/1ns
module acc_ctrl_properties
  import acc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] conv_result,
  input wire logic conv_clk,
  input wire logic conv_busy,
  input wire logic cpu_halt,
  input wire acc_analog_t analog_cfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ans; $rose(penable) && psel |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("ready not one cycle after take");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_halt; cpu_halt == conv_busy; endproperty
  a_halt: assert property (p_halt) else $error("halt differs from busy");
  property p_idle; !conv_busy && !$past(conv_busy) |-> !conv_clk; endproperty
  a_idle: assert property (p_idle) else $error("conversion clock runs idle");
  // fastest divisor still gives a 50-cycle half period
  property p_slow; $rose(conv_clk) |=> conv_clk [*8]; endproperty
  a_slow: assert property (p_slow) else $error("conversion clock too fast");
  property p_force;
    conv_busy && analog_cfg.plus_node inside {ACC_NODE_SUPPLY, ACC_NODE_GROUND,
      ACC_NODE_DAC_SMALL, ACC_NODE_DAC_LARGE}
      |-> analog_cfg.gain_forced && analog_cfg.amp_gain_code == 5'h1F;
  endproperty
  a_force: assert property (p_force) else $error("gain not forced");
  property p_gnd;
    conv_busy && analog_cfg.plus_node inside {ACC_NODE_SMALL_AMP, ACC_NODE_LARGE_AMP,
      ACC_NODE_BANDGAP, ACC_NODE_SUPPLY} |-> analog_cfg.minus_is_ground;
  endproperty
  a_gnd: assert property (p_gnd) else $error("minus input not ground");
  property p_go;
    psel && penable && pwrite && paddr == 32'h0 && pwdata[2] && !conv_busy && !pready
      |-> ##[1:3] conv_busy;
  endproperty
  a_go: assert property (p_go) else $error("start bit did not launch");
  c_busy: cover property ($rose(conv_busy));
  c_err: cover property (pslverr);
  c_force: cover property (analog_cfg.gain_forced && conv_busy);
endmodule

// ==== tb/acc_ctrl_bench.sv ====
// self-checking bench for the adc setup block
`timescale 1ns/1ns
module acc_ctrl_bench;
  import acc_pkg::*;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic conv_clk, conv_busy, cpu_halt;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] conv_result;
  acc_analog_t analog_cfg;
  int fail_count, tests_run, cyc;
  localparam logic [7:0] IDX [6] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09};
  localparam logic [15:0] RSTV [6] = '{16'h0, 16'h70, 16'h0, 16'h70, 16'h0, 16'h70};
  localparam logic [15:0] MSK [6] = '{16'hFF7F, 16'h73, 16'hFF7F, 16'h73, 16'hFF7F, 16'h70};
  acc_ctrl acc_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_result(conv_result),
    .conv_clk(conv_clk), .conv_busy(conv_busy), .cpu_halt(cpu_halt),
    .analog_cfg(analog_cfg));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {16'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, IDX[i], 16'h0);
      chk(rd, {16'h0, RSTV[i]});
      apb(1'b1, IDX[i], 16'hFFFF);
      apb(1'b0, IDX[i], 16'h0);
      chk(rd, {16'h0, MSK[i]});
    end
    apb(1'b0, 8'h0B, 16'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_pick(input logic [15:0] cw, input acc_ch_t ch, input acc_ref_t rs,
                        input logic [2:0] bias, input logic [31:0] st);
    apb(1'b1, 8'h05, 16'h9000);
    apb(1'b1, 8'h06, 16'h0062);
    apb(1'b1, 8'h09, 16'h0050);
    apb(1'b1, 8'h00, cw);
    repeat (2) @(posedge clk_sys);
    chk(analog_cfg.channel, ch);
    chk({31'h0, cpu_halt}, {31'h0, ch != ACC_CH_NONE});
    if (ch != ACC_CH_NONE) begin
      chk(analog_cfg.bias_level_code, bias);
      chk(analog_cfg.reference_select, rs);
    end
    apb(1'b0, 8'h0A, 16'h0);
    chk(rd, st);
    // a reset in mid-run must abort the conversion and restore the setup values
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    chk({30'h0, conv_busy, conv_clk}, 32'h0);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h06, 16'h0);
    chk(rd, 32'h70);
    apb(1'b0, 8'h00, 16'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_conv(input logic [3:0] src, input logic [15:0] sa, input logic [15:0] sb,
                        input acc_node_t node, input logic frc, input acc_ref_t rs);
    longint t0, t1;
    int n;
    apb(1'b1, 8'h02, sa);
    apb(1'b1, 8'h03, sb);
    conv_result <= {12'hA5C, src};
    apb(1'b1, 8'h00, {4'h0, src, 8'h04});
    n = 0;
    while (conv_busy !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    t0 = $time;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cpu_halt}, 32'h1);
    chk(analog_cfg.channel, ACC_CH_ONE);
    chk(analog_cfg.plus_node, node);
    chk({31'h0, analog_cfg.minus_is_ground}, 32'h1);
    chk(analog_cfg.amp_gain_code, frc ? 5'h1F : sa[15:11]);
    chk({31'h0, analog_cfg.gain_forced}, {31'h0, frc});
    chk({analog_cfg.coarse_offset_sign, analog_cfg.coarse_offset_magnitude}, sa[3:0]);
    chk(analog_cfg.bias_level_code, sb[6:4]);
    chk(analog_cfg.reference_select, rs);
    chk(analog_cfg.res_bits, 4'h9);
    apb(1'b1, 8'h02, 16'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h0A, 16'h0);
    chk(rd, 32'h1);
    @(posedge conv_clk);
    t1 = $time;
    @(posedge conv_clk);
    chk(32'($time - t1), 32'h3E8);
    while (conv_busy === 1'b1) @(posedge clk_sys);
    // 256 conversion clocks of 100 system cycles each
    chk(32'(($time - t0) / 10 > 25500 && ($time - t0) / 10 < 25700), 32'h1);
    apb(1'b0, 8'h00, 16'h0);
    chk(rd, {20'h0, src, 8'h00});
    apb(1'b0, 8'h01, 16'h0);
    chk(rd, {20'h0A5C, src});
    apb(1'b0, 8'h02, 16'h0);
    chk(rd, {16'h0, sa});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    conv_result = 16'h0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_pick(16'h0003, ACC_CH_TWO, ACC_REF_BG4X, 3'h6, 32'h3);
    t_pick(16'h0001, ACC_CH_TEMP, ACC_REF_SUPPLY, 3'h5, 32'h1);
    t_pick(16'h0101, ACC_CH_NONE, ACC_REF_SUPPLY, 3'h0, 32'h0);
    t_conv(4'h4, 16'h180D, 16'h0071, ACC_NODE_SUPPLY, 1'b1, ACC_REF_EXT2X);
    t_conv(4'h8, 16'hF00A, 16'h0052, ACC_NODE_POS_PIN, 1'b0, ACC_REF_BG4X);
    summarize;
  end
endmodule
bind acc_ctrl acc_ctrl_properties acc_ctrl_properties_i (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_result(conv_result), .conv_clk(conv_clk), .conv_busy(conv_busy),
  .cpu_halt(cpu_halt), .analog_cfg(analog_cfg));
